// ==== hdl/sba_arbiter.sv ====
// How it works
// - A 9-bit counter with its own overflow bit, steered by the control register.
// - Mode 00 idle and reset, 01 bit time measurement, 10 bus arbitration, 11 reserved.
// - Lost flag sets on lost arbitration; writing zero to the high mode bit clears it.
// - Clock select 0 counts bus clock over four; 1 counts half the prescaler output.
// - A configuration bit chooses bus clock or fast oscillator clock for the prescaler.
// - Done flag sets when a measurement ends; any control write clears it.
// - Running flag reads 1 while the counter counts, 0 while stopped.
// - Overflow flag sets when the counter wraps; any control write clears it.
// - Writing 00 to the mode resets the counter and holds it there.
// - Counter top bit is readable in the control register; control writes clear it.
// - Low eight counter bits read from the data register; control writes clear them.
// - Select 0 measurement runs from one receive falling edge to the next.
// - Select 1 measurement runs while receive is low, stops on its rising edge.
// - Arbitration starts on transmit rise, samples receive at 0x38 or 0x08, low loses.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module sba_arbiter (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdata,
	input  wire logic       rxLine,
	input  wire logic       shiftRegisterTxOut,
	input  wire logic       prescalerTick,
	output logic            txPin,
	output logic            prescalerSourceSelect
);

	// ----------------------------------------------------------------
	// State of the whole block.
	// ----------------------------------------------------------------
	typedef struct packed {
		sba_pkg::sba_mode_t mode;
		logic               aclk;
		logic               lost;
		logic               fin;
		logic               run;
		logic               ovfl;
		logic [8:0]         cnt;
		logic               armed;
		logic               rxPrev;
		logic               txPrev;
		logic               srcSel;
		logic               txOut;
		logic [7:0]         rdata;
	} sba_state_t;

	sba_state_t st_q;
	sba_state_t st_d;
	logic       countTick;

	// Counter advance pulse from the selected source.
	sba_tick_gen u_tick (
		.core_clk      (core_clk),
		.reset         (reset),
		.aclkSel       (st_q.aclk),
		.prescalerTick (prescalerTick),
		.countTick     (countTick)
	);

	// ----------------------------------------------------------------
	// Decoded strobes and edge events.
	// ----------------------------------------------------------------
	logic ctrlWrite;
	logic cfgWrite;
	logic rxFall;
	logic rxRise;
	logic txRise;
	logic advance;
	logic wrap;
	logic finSet;
	logic lostSet;
	logic ovflSet;
	logic [8:0] sampleAt;

	// Edges are seen against last cycle's level; inputs are already synchronous.
	assign ctrlWrite = regWrite && (regAddr == sba_pkg::ADDR_CONTROL);
	assign cfgWrite  = regWrite && (regAddr == sba_pkg::ADDR_CONFIG);
	assign rxFall    = st_q.rxPrev && !rxLine;
	assign rxRise    = !st_q.rxPrev && rxLine;
	assign txRise    = !st_q.txPrev && shiftRegisterTxOut;
	assign advance   = st_q.run && countTick;
	assign wrap      = advance && (st_q.cnt == sba_pkg::CNT_MAX);
	assign sampleAt  = st_q.aclk ? sba_pkg::SAMPLE_PRESC : sba_pkg::SAMPLE_BUSDIV;

	// Flag set events, evaluated in the mode that is in force this cycle.
	always_comb begin
		finSet  = 1'b0;
		lostSet = 1'b0;
		ovflSet = wrap;
		if (st_q.mode == sba_pkg::SBA_MODE_MEAS && st_q.run) begin
			if (st_q.aclk) begin
				finSet = rxRise;
			end else begin
				finSet = rxFall;
			end
		end
		if (st_q.mode == sba_pkg::SBA_MODE_ARB && st_q.armed && st_q.run &&
			st_q.cnt == sampleAt && !rxLine) begin
			lostSet = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Next state.
	// ----------------------------------------------------------------
	// Clears from a software write are applied first, so a hardware event in
	// the same cycle still lands; a lost flag or done flag is never dropped.
	always_comb begin
		st_d        = st_q;
		st_d.rxPrev = rxLine;
		st_d.txPrev = shiftRegisterTxOut;

		// Counting and mode behaviour.
		case (st_q.mode)
			sba_pkg::SBA_MODE_MEAS: begin
				st_d.armed = 1'b0;
				if (st_q.run) begin
					if (finSet) begin
						st_d.run = 1'b0;
					end else if (advance) begin
						st_d.cnt = st_q.cnt + 9'h001;
					end
				end else if (!st_q.fin) begin
					// Select 1 starts on a low level, so a low line at enable
					// starts at once; select 0 waits for a true falling edge.
					if (st_q.aclk ? !rxLine : rxFall) begin
						st_d.run = 1'b1;
					end
				end
			end
			sba_pkg::SBA_MODE_ARB: begin
				if (txRise) begin
					st_d.cnt   = '0;
					st_d.run   = 1'b1;
					st_d.armed = 1'b1;
				end else if (st_q.armed && !shiftRegisterTxOut) begin
					// Transmit went low before the sense point was reached:
					// restart and wait for the next rising edge.
					st_d.cnt   = '0;
					st_d.run   = 1'b0;
					st_d.armed = 1'b0;
				end else begin
					if (st_q.armed && st_q.run && st_q.cnt == sampleAt) begin
						st_d.armed = 1'b0; // Sense only once per bit.
					end
					if (advance) begin
						st_d.cnt = st_q.cnt + 9'h001;
					end
				end
			end
			sba_pkg::SBA_MODE_RSVD: begin
				st_d.cnt   = '0;
				st_d.run   = 1'b0;
				st_d.armed = 1'b0;
			end
			default: begin
				st_d.cnt   = '0;
				st_d.run   = 1'b0;
				st_d.armed = 1'b0;
			end
		endcase

		// Software write to the control register.
		if (ctrlWrite) begin
			st_d.mode = sba_pkg::sba_mode_t'(regWdata[sba_pkg::BIT_MODE_HI:sba_pkg::BIT_MODE_LO]);
			st_d.aclk = regWdata[sba_pkg::BIT_ACLK];
			st_d.fin  = 1'b0;
			st_d.ovfl = 1'b0;
			st_d.cnt  = '0;
			if (!regWdata[sba_pkg::BIT_MODE_HI]) begin
				st_d.lost = 1'b0;
			end
		end
		if (cfgWrite) begin
			st_d.srcSel = regWdata[sba_pkg::BIT_SRC_SEL];
		end

		// Hardware sets win over the clears above.
		if (finSet) begin
			st_d.fin = 1'b1;
		end
		if (ovflSet) begin
			st_d.ovfl = 1'b1;
		end
		if (lostSet) begin
			st_d.lost = 1'b1;
		end

		// The pin follows the shifter unless arbitration was lost.
		st_d.txOut = shiftRegisterTxOut | st_q.lost | lostSet;

		// Read data stand for exactly one cycle after the strobe.
		st_d.rdata = sba_pkg::RESET_RDATA;
		if (regRead) begin
			case (regAddr)
				sba_pkg::ADDR_CONTROL: begin
					st_d.rdata = {st_q.mode, st_q.lost, st_q.aclk,
						st_q.fin, st_q.run, st_q.ovfl, st_q.cnt[8]};
				end
				sba_pkg::ADDR_DATA: begin
					st_d.rdata = st_q.cnt[7:0];
				end
				sba_pkg::ADDR_CONFIG: begin
					st_d.rdata = {7'h00, st_q.srcSel};
				end
				default: begin
					st_d.rdata = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register.
	// ----------------------------------------------------------------
	// The idle line level is high, so edge history starts high to avoid a
	// false rising edge on the first cycle after reset.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q        <= '0;
			st_q.rxPrev <= 1'b1;
			st_q.txPrev <= 1'b1;
			st_q.txOut  <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign regRdata              = st_q.rdata;
	assign txPin                 = st_q.txOut;
	assign prescalerSourceSelect = st_q.srcSel;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	a_mode_store: assert property (@(posedge core_clk) disable iff (reset)
		ctrlWrite |=> st_q.mode == $past(regWdata[7:6]))
		else $error("Mode field did not take the written value.");

	a_lost_clear: assert property (@(posedge core_clk) disable iff (reset)
		ctrlWrite && !regWdata[7] && !lostSet |=> !st_q.lost)
		else $error("Lost flag survived a write of zero to the high mode bit.");

	a_count_on_tick: assert property (@(posedge core_clk) disable iff (reset)
		st_q.run && !ctrlWrite && !txRise && !countTick &&
		!(st_q.mode == sba_pkg::SBA_MODE_ARB && st_q.armed && !shiftRegisterTxOut)
		|=> $stable(st_q.cnt))
		else $error("Counter moved without an advance pulse.");

	a_src_select: assert property (@(posedge core_clk) disable iff (reset)
		cfgWrite |=> prescalerSourceSelect == $past(regWdata[0]))
		else $error("Prescaler source did not follow the configuration write.");

	a_fin_clear: assert property (@(posedge core_clk) disable iff (reset)
		ctrlWrite && !finSet |=> !st_q.fin)
		else $error("Done flag survived a control write.");

	a_idle_stopped: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_IDLE ##1 st_q.mode == sba_pkg::SBA_MODE_IDLE
		|-> !st_q.run && st_q.cnt == 9'h000)
		else $error("Counter not held reset in idle.");

	a_ovfl_set: assert property (@(posedge core_clk) disable iff (reset)
		wrap |=> st_q.ovfl)
		else $error("Overflow flag missed a counter wrap.");

	a_write_clr_cnt: assert property (@(posedge core_clk) disable iff (reset)
		ctrlWrite |=> st_q.cnt == 9'h000)
		else $error("Counter not cleared by a control write.");

	a_read_low: assert property (@(posedge core_clk) disable iff (reset)
		regRead && regAddr == sba_pkg::ADDR_DATA |=> regRdata == $past(st_q.cnt[7:0]))
		else $error("Data register read did not return the counter low bits.");

	a_meas_stop: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_MEAS && !st_q.aclk && st_q.run && rxFall
		|=> st_q.fin && !st_q.run)
		else $error("Measurement did not stop on the second falling edge.");

	a_meas_lowstart: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_MEAS && st_q.aclk && !st_q.run && !st_q.fin &&
		!rxLine && !ctrlWrite |=> st_q.run)
		else $error("Low receive line did not start the measurement.");

	a_arb_start: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_ARB && txRise && !ctrlWrite
		|=> st_q.run && st_q.cnt == 9'h000)
		else $error("Arbitration counter did not start on transmit rise.");

	a_lost_forces: assert property (@(posedge core_clk) disable iff (reset)
		st_q.lost |=> txPin)
		else $error("Transmit pin not forced high after arbitration loss.");

	a_rsvd_hold: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_RSVD && !ctrlWrite
		|=> st_q.cnt == 9'h000 && $stable(st_q.fin) && $stable(st_q.lost))
		else $error("Reserved mode did not behave as idle.");

	a_lost_hold: assert property (@(posedge core_clk) disable iff (reset)
		st_q.lost && !(ctrlWrite && !regWdata[sba_pkg::BIT_MODE_HI]) |=> st_q.lost)
		else $error("Lost flag dropped without a clearing write.");

	a_ovfl_clear: assert property (@(posedge core_clk) disable iff (reset)
		ctrlWrite && !ovflSet |=> !st_q.ovfl)
		else $error("Overflow flag survived a control write.");

	a_msb_read: assert property (@(posedge core_clk) disable iff (reset)
		regRead && regAddr == sba_pkg::ADDR_CONTROL |=> regRdata[0] == $past(st_q.cnt[8]))
		else $error("Control read did not return the counter top bit.");

	a_meas_start0: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_MEAS && !st_q.aclk && !st_q.run && !st_q.fin &&
		rxFall |=> st_q.run)
		else $error("Falling receive edge did not start the measurement.");

	a_meas_rise1: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_MEAS && st_q.aclk && st_q.run && rxRise
		|=> st_q.fin && !st_q.run)
		else $error("Measurement did not stop on the receive rise.");

	a_meas_count: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_MEAS && advance && !finSet && !ctrlWrite
		|=> st_q.cnt == $past(st_q.cnt) + 9'h001)
		else $error("Running counter did not step on an advance pulse.");

	a_arb_sense: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_ARB && st_q.armed && st_q.run &&
		st_q.cnt == sampleAt && !rxLine |=> st_q.lost)
		else $error("Dominant receive at the sense point did not set the lost flag.");

	a_arb_restart: assert property (@(posedge core_clk) disable iff (reset)
		st_q.mode == sba_pkg::SBA_MODE_ARB && st_q.armed && !shiftRegisterTxOut &&
		!ctrlWrite |=> !st_q.run && st_q.cnt == 9'h000)
		else $error("Transmit low before the sense point did not restart the count.");

	a_tx_follow: assert property (@(posedge core_clk) disable iff (reset)
		!st_q.lost && !lostSet |=> txPin == $past(shiftRegisterTxOut))
		else $error("Transmit pin did not follow the shifter while arbitration held.");

endmodule // sba_arbiter
`default_nettype wire

// ==== hdl/sba_pkg.sv ====
`default_nettype none

package sba_pkg;

	// ----------------------------------------------------------------
	// Register map of the plain software port.
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_DATA    = 2'h1;
	localparam logic [1:0] ADDR_CONFIG  = 2'h2;

	// ----------------------------------------------------------------
	// Field positions of arbiter_control_reg and of the config register.
	// ----------------------------------------------------------------
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_LOST    = 5;
	localparam int BIT_ACLK    = 4;
	localparam int BIT_FIN     = 3;
	localparam int BIT_RUN     = 2;
	localparam int BIT_OVFL    = 1;
	localparam int BIT_MSB     = 0;
	localparam int BIT_SRC_SEL = 0;

	// ----------------------------------------------------------------
	// Modes, widths and counts.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SBA_MODE_IDLE  = 2'h0,
		SBA_MODE_MEAS  = 2'h1,
		SBA_MODE_ARB   = 2'h2,
		SBA_MODE_RSVD  = 2'h3
	} sba_mode_t;

	localparam int         CNT_W          = 9;
	localparam logic [8:0] CNT_MAX        = 9'h1ff;
	localparam logic [8:0] SAMPLE_BUSDIV  = 9'h038;
	localparam logic [8:0] SAMPLE_PRESC   = 9'h008;
	localparam logic [1:0] BUS_DIV_LAST   = 2'h3;
	localparam logic [7:0] RESET_CONTROL  = 8'h00;
	localparam logic [7:0] RESET_RDATA    = 8'h00;

endpackage
`default_nettype wire

// ==== hdl/sba_tick_gen.sv ====
`timescale 1ns/10ps
`default_nettype none

// Produces the one-cycle advance pulse of the arbiter counter.
module sba_tick_gen (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic aclkSel,
	input  wire logic prescalerTick,
	output logic      countTick
);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] busDiv;
		logic       halfPhase;
		logic       tick;
	} sba_tick_state_t;

	sba_tick_state_t st_q;
	sba_tick_state_t st_d;

	// Both dividers run freely so a change of source never waits for a restart.
	always_comb begin
		st_d           = st_q;
		st_d.busDiv    = st_q.busDiv + 2'h1;
		if (prescalerTick) begin
			st_d.halfPhase = ~st_q.halfPhase;
		end
		if (aclkSel) begin
			st_d.tick = prescalerTick & st_q.halfPhase;
		end else begin
			st_d.tick = (st_q.busDiv == sba_pkg::BUS_DIV_LAST);
		end
	end

	// Registers the state.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign countTick = st_q.tick;

endmodule // sba_tick_gen
`default_nettype wire

// ==== dv/sba_bus_node.sv ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Other nodes sharing the wired-AND serial bus.
// ----------------------------------------------------------------
module sba_bus_node (
	input  wire logic txPin,
	input  wire logic nodeLow,
	output logic      rxLine
);
	// A dominant low from any node wins; an undriven pin reads high by the pull-up.
	assign rxLine = (txPin !== 1'b0) & ~nodeLow;
endmodule // sba_bus_node
`default_nettype wire

// ==== dv/serial_bus_arbiter_counter_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module serial_bus_arbiter_counter_bench;
	logic       core_clk;
	logic       reset;
	logic [1:0] regAddr;
	logic [7:0] regWdata;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regRdata;
	logic       rxLine;
	logic       shiftRegisterTxOut;
	logic       prescalerTick = 1'b0;
	logic       txPin;
	logic       prescalerSourceSelect;
	logic       nodeLow;
	logic [1:0] pdiv = 2'h0;
	logic [7:0] rd;
	integer     seed;
	integer     error_cnt;
	integer     n_tests;
	integer     d;
	integer     s;
	integer     w;

	sba_arbiter u_sba_arbiter (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.rxLine(rxLine), .shiftRegisterTxOut(shiftRegisterTxOut),
		.prescalerTick(prescalerTick), .txPin(txPin),
		.prescalerSourceSelect(prescalerSourceSelect));
	sba_bus_node u_sba_bus_node (.txPin(txPin), .nodeLow(nodeLow), .rxLine(rxLine));

	// ----------------------------------------------------------------
	// Clock and a baud prescaler that ticks every third cycle.
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// The tick runs free so that select 1 always has a count source.
	always @(posedge core_clk) begin
		pdiv <= (pdiv == 2'h2) ? 2'h0 : pdiv + 2'h1;
		prescalerTick <= (pdiv == 2'h2);
	end

	// ----------------------------------------------------------------
	// Bus tasks, comparison and closing report.
	// ----------------------------------------------------------------
	task automatic cyc(input integer n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so sample it there.
	task automatic rdr(input logic [1:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 rd = regRdata;
	endtask

	task automatic chk(input logic [8:0] got, input integer lo, input integer hi);
		n_tests++;
		if ($isunknown(got) || got < lo || got > hi) begin
			error_cnt++;
			$display("[FAIL] %0t got %0h want %0h..%0h", $time, got, lo, hi);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		seed = 49;
		error_cnt = 0;
		n_tests = 0;
		reset = 1'b1;
		regAddr = 2'h0;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		shiftRegisterTxOut = 1'b1;
		nodeLow = 1'b0;
		cyc(12);
		reset <= 1'b0;
		// Every address, the unmapped one too, reads zero after reset.
		for (w = 0; w < 4; w++) begin
			rdr(w[1:0]);
			chk(rd, 0, 0);
		end
		chk(txPin, 1, 1);
		$display("test reset done");
		// Only bit 0 of the config register holds; data and unmapped writes vanish.
		wr(sba_pkg::ADDR_CONFIG, 8'hff);
		wr(sba_pkg::ADDR_DATA, 8'hff);
		wr(2'h3, 8'hff);
		rdr(sba_pkg::ADDR_CONFIG);
		chk(rd, 1, 1);
		chk(prescalerSourceSelect, 1, 1);
		rdr(sba_pkg::ADDR_DATA);
		chk(rd, 0, 0);
		$display("test config done");
		// Random gaps between two receive falls, counted at a quarter of the clock.
		for (s = 0; s < 3; s++) begin
			d = 40 + ($unsigned($random(seed)) % 200);
			wr(sba_pkg::ADDR_CONTROL, 8'h40);
			nodeLow <= 1'b1;
			cyc(2);
			nodeLow <= 1'b0;
			rdr(sba_pkg::ADDR_CONTROL);
			chk(rd, 8'h44, 8'h44);
			cyc(d - 4);
			nodeLow <= 1'b1;
			cyc(4);
			nodeLow <= 1'b0;
			rdr(sba_pkg::ADDR_DATA);
			chk(rd, d / 4 - 1, d / 4 + 1);
			rdr(sba_pkg::ADDR_CONTROL);
			chk(rd, 8'h48, 8'h48);
		end
		wr(sba_pkg::ADDR_CONTROL, 8'h10);
		rdr(sba_pkg::ADDR_DATA);
		chk(rd, 0, 0);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd, 8'h10, 8'h10);
		$display("test measure0 done");
		// Receive already low at enable starts the count at once; it ends on the rise.
		d = 60 + ($unsigned($random(seed)) % 180);
		nodeLow <= 1'b1;
		wr(sba_pkg::ADDR_CONTROL, 8'h50);
		cyc(d);
		nodeLow <= 1'b0;
		cyc(4);
		rdr(sba_pkg::ADDR_DATA);
		chk(rd, d / 6 - 2, d / 6 + 2);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd, 8'h58, 8'h58);
		$display("test measure1 done");
		// A long measurement wraps past 0x1ff, then climbs over 0xff again.
		wr(sba_pkg::ADDR_CONTROL, 8'h40);
		nodeLow <= 1'b1;
		cyc(2);
		nodeLow <= 1'b0;
		cyc(2100);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd, 8'h46, 8'h46);
		wr(sba_pkg::ADDR_CONTROL, 8'h40);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd[1], 0, 0);
		cyc(1100);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd[0], 1, 1);
		// The reserved code must hold the counter at zero like idle does.
		wr(sba_pkg::ADDR_CONTROL, 8'hc0);
		cyc(20);
		rdr(sba_pkg::ADDR_DATA);
		chk(rd, 0, 0);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd, 8'hc0, 8'hc0);
		$display("test overflow done");
		// Transmit falls back before the sense point: the count restarts and waits.
		wr(sba_pkg::ADDR_CONTROL, 8'h80);
		shiftRegisterTxOut <= 1'b0;
		cyc(3);
		shiftRegisterTxOut <= 1'b1;
		cyc(20);
		shiftRegisterTxOut <= 1'b0;
		cyc(3);
		rdr(sba_pkg::ADDR_CONTROL);
		chk(rd, 8'h80, 8'h80);
		rdr(sba_pkg::ADDR_DATA);
		chk(rd, 0, 0);
		// Another node holds the bus low; the sample at 0x38 or 0x08 must lose.
		for (s = 0; s < 2; s++) begin
			wr(sba_pkg::ADDR_CONTROL, s ? 8'h90 : 8'h80);
			shiftRegisterTxOut <= 1'b0;
			cyc(3);
			nodeLow <= 1'b1;
			shiftRegisterTxOut <= 1'b1;
			w = s ? 8'h08 * 6 : 8'h38 * 4;
			cyc(w - 10);
			rdr(sba_pkg::ADDR_CONTROL);
			chk(rd, s ? 8'h94 : 8'h84, s ? 8'h94 : 8'h84);
			cyc(20);
			rdr(sba_pkg::ADDR_CONTROL);
			chk(rd[5], 1, 1);
			shiftRegisterTxOut <= 1'b0;
			cyc(3);
			#1;
			chk(txPin, 1, 1);
			wr(sba_pkg::ADDR_CONTROL, 8'h80);
			rdr(sba_pkg::ADDR_CONTROL);
			chk(rd[5], 1, 1);
			wr(sba_pkg::ADDR_CONTROL, 8'h00);
			rdr(sba_pkg::ADDR_CONTROL);
			chk(rd, 0, 0);
			nodeLow <= 1'b0;
			shiftRegisterTxOut <= 1'b1;
		end
		$display("test arbitration done");
		summarize();
	end
endmodule // serial_bus_arbiter_counter_bench
`default_nettype wire
